// ==== rtl/sdt_pkg.sv ====
// constants, register map and carrier types for the split dual byte pwm timer
package sdt_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CLK_SEL    = 8'h00;
    localparam logic [7:0] ADDR_OUT_EN     = 8'h01;
    localparam logic [7:0] ADDR_OUT_VALUE  = 8'h02;
    localparam logic [7:0] ADDR_BYTE_MODE  = 8'h04;
    localparam logic [7:0] ADDR_UF_LEVEL   = 8'h06;
    localparam logic [7:0] ADDR_CMP_LEVEL  = 8'h07;
    localparam logic [7:0] ADDR_COMMAND    = 8'h08;
    localparam logic [7:0] ADDR_FLAGS      = 8'h0C;
    localparam logic [7:0] ADDR_LOWER_CNT  = 8'h20;
    localparam logic [7:0] ADDR_LOWER_PER  = 8'h26;
    localparam logic [7:0] ADDR_LOWER_CMP  = 8'h28;
    localparam logic [7:0] CMP_ADDR_STRIDE = 8'h02;

    // count clock source select codes
    localparam logic [3:0] CLK_OFF      = 4'h0;
    localparam logic [3:0] CLK_DIV1     = 4'h1;
    localparam logic [3:0] CLK_DIV2     = 4'h2;
    localparam logic [3:0] CLK_DIV4     = 4'h3;
    localparam logic [3:0] CLK_DIV8     = 4'h4;
    localparam logic [3:0] CLK_DIV64    = 4'h5;
    localparam logic [3:0] CLK_DIV256   = 4'h6;
    localparam logic [3:0] CLK_DIV1024  = 4'h7;
    localparam int         CLK_EVENT_BIT = 3;
    localparam int         PRESCALE_W    = 10;

    // byte operation select codes
    localparam logic [1:0] MODE_NORMAL        = 2'h0;
    localparam logic [1:0] MODE_UPPER_CLEARED = 2'h1;
    localparam logic [1:0] MODE_SPLIT         = 2'h2;

    // command register fields and codes
    localparam int         CMD_LSB        = 2;
    localparam int         CMD_TARGET_LSB = 0;
    localparam logic [1:0] CMD_NONE       = 2'h0;
    localparam logic [1:0] CMD_RESTART    = 2'h2;
    localparam logic [1:0] CMD_RESET      = 2'h3;

    // flag register layout
    localparam int FLAG_LOWER_UF  = 0;
    localparam int FLAG_UPPER_UF  = 1;
    localparam int FLAG_MATCH_LSB = 4;

    // reset values
    localparam logic [7:0] PER_RESET = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       dma;
    } sdt_bus_req_t;

    typedef struct packed {
        logic [3:0] lower_match;
        logic       upper_uf;
        logic       lower_uf;
    } sdt_events_t;

endpackage

// ==== rtl/sdt_timer.sv ====
// split dual byte pwm timer: two down-counters, eight pwm channels, flags, events, dma requests
`timescale 1ns/10ps
`default_nettype none

module sdt_timer #(
    parameter int CNT_W   = 8,
    parameter int EV_CHAN = 8
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // register port
    input  wire sdt_pkg::sdt_bus_req_t bus_req,
    output logic [7:0]                rd_data,
    // event system count inputs
    input  wire logic [EV_CHAN-1:0]   ev_chan,
    // port pin side
    input  wire logic [7:0]           port_output_value,
    input  wire logic [7:0]           pin_invert_enable,
    input  wire logic [7:0]           pin_dir_out,
    output logic [7:0]                pin_out,
    output logic [7:0]                pin_oe_n,
    // events, interrupt and dma requests
    output sdt_pkg::sdt_events_t      events_out,
    output logic [5:0]                irq_req,
    output logic [5:0]                dma_req
);

    if (CNT_W < 2 || CNT_W > 8) begin : g_bad_width
        $error("CNT_W must be 2..8");
    end
    if (EV_CHAN != 8) begin : g_bad_chan
        $error("EV_CHAN must be 8");
    end

    localparam int PRESCALE_W = sdt_pkg::PRESCALE_W;

    logic [3:0]            count_clock_source_select;
    logic [1:0]            byte_operation_select;
    logic [3:0]            lower_channel_output_enable;
    logic [3:0]            upper_channel_output_enable;
    logic [3:0]            uf_level_reg;
    logic [7:0]            cmp_level_reg;
    logic [7:0]            flags_reg;
    logic [PRESCALE_W-1:0] prescale_reg;
    logic [CNT_W-1:0]      cnt_reg [2];
    logic [CNT_W-1:0]      per_reg [2];
    logic [CNT_W-1:0]      cmp_reg [2][4];
    logic [7:0]            wg_reg;
    logic [7:0]            rd_data_reg;
    logic [7:0]            rd_data_next;
    logic [7:0]            pin_out_reg;
    logic [7:0]            pin_oe_n_reg;
    logic [5:0]            irq_req_reg;
    logic [5:0]            dma_req_reg;
    sdt_pkg::sdt_events_t  events_reg;

    logic       wr;
    logic       rd;
    logic [1:0] cmd;
    logic [1:0] command_target_enable;
    logic       soft_reset;
    logic       split_on;
    logic       timer_off;
    logic       prescale_hit;
    logic       count_tick;
    logic [1:0] restart;
    logic [1:0] at_bottom;
    logic [7:0] match;
    logic [7:0] flags_set;
    logic [7:0] flags_clr;

    // decodes which lower compare channel, if any, an address selects
    function automatic logic [3:0] lower_cmp_hit(input logic [7:0] a);
        logic [3:0] hit;
        hit = 4'h0;
        for (int i = 0; i < 4; i++) begin
            hit[i] = (a == 8'(sdt_pkg::ADDR_LOWER_CMP + 8'(i) * sdt_pkg::CMP_ADDR_STRIDE));
        end
        return hit;
    endfunction

    assign wr  = bus_req.wr;
    assign rd  = bus_req.rd;
    assign cmd = bus_req.wdata[sdt_pkg::CMD_LSB +: 2];
    assign command_target_enable = bus_req.wdata[sdt_pkg::CMD_TARGET_LSB +: 2];
    assign timer_off = (count_clock_source_select == sdt_pkg::CLK_OFF);
    assign split_on  = (byte_operation_select == sdt_pkg::MODE_SPLIT);

    // reset command honoured only while the timer is stopped
    assign soft_reset = wr && bus_req.addr == sdt_pkg::ADDR_COMMAND && cmd == sdt_pkg::CMD_RESET
                        && command_target_enable != 2'h0 && timer_off;

    // common prescaler, free running
    always_ff @(posedge clock) begin
        if (rst) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + 1'b1;
        end
    end

    always_comb begin
        case (count_clock_source_select[2:0])
            3'h1:    prescale_hit = 1'b1;
            3'h2:    prescale_hit = &prescale_reg[0:0];
            3'h3:    prescale_hit = &prescale_reg[1:0];
            3'h4:    prescale_hit = &prescale_reg[2:0];
            3'h5:    prescale_hit = &prescale_reg[5:0];
            3'h6:    prescale_hit = &prescale_reg[7:0];
            3'h7:    prescale_hit = &prescale_reg[9:0];
            default: prescale_hit = 1'b0;
        endcase
    end

    // one shared count clock for both halves
    always_comb begin
        if (count_clock_source_select[sdt_pkg::CLK_EVENT_BIT]) begin
            count_tick = split_on && ev_chan[count_clock_source_select[2:0]];
        end else begin
            count_tick = split_on && !timer_off && prescale_hit;
        end
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (rst || soft_reset) begin
            count_clock_source_select   <= sdt_pkg::CLK_OFF;
            byte_operation_select       <= sdt_pkg::MODE_NORMAL;
            lower_channel_output_enable <= '0;
            upper_channel_output_enable <= '0;
            uf_level_reg                <= '0;
            cmp_level_reg               <= '0;
        end else if (wr) begin
            case (bus_req.addr)
                sdt_pkg::ADDR_CLK_SEL: count_clock_source_select <= bus_req.wdata[3:0];
                sdt_pkg::ADDR_OUT_EN: begin
                    lower_channel_output_enable <= bus_req.wdata[3:0];
                    upper_channel_output_enable <= bus_req.wdata[7:4];
                end
                sdt_pkg::ADDR_BYTE_MODE: byte_operation_select <= bus_req.wdata[1:0];
                sdt_pkg::ADDR_UF_LEVEL:  uf_level_reg <= bus_req.wdata[3:0];
                sdt_pkg::ADDR_CMP_LEVEL: cmp_level_reg <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // the two byte counters, h = 0 lower, h = 1 upper
    for (genvar h = 0; h < 2; h++) begin : g_half
        localparam logic [7:0] A_CNT = 8'(sdt_pkg::ADDR_LOWER_CNT + 8'(h));
        localparam logic [7:0] A_PER = 8'(sdt_pkg::ADDR_LOWER_PER + 8'(h));
        logic cnt_wr;
        logic per_wr;

        assign cnt_wr     = wr && bus_req.addr == A_CNT;
        assign per_wr     = wr && bus_req.addr == A_PER;
        assign restart[h] = wr && bus_req.addr == sdt_pkg::ADDR_COMMAND
                            && cmd == sdt_pkg::CMD_RESTART && command_target_enable[h];
        assign at_bottom[h] = (cnt_reg[h] == '0);

        always_ff @(posedge clock) begin
            if (rst || soft_reset) begin
                cnt_reg[h] <= '0;
            end else if (cnt_wr) begin
                cnt_reg[h] <= bus_req.wdata[CNT_W-1:0];
            end else if (restart[h]) begin
                cnt_reg[h] <= '0;
            end else if (count_tick) begin
                if (at_bottom[h]) begin
                    cnt_reg[h] <= per_reg[h];
                end else begin
                    cnt_reg[h] <= cnt_reg[h] - 1'b1;
                end
            end
        end

        always_ff @(posedge clock) begin
            if (rst || soft_reset) begin
                per_reg[h] <= sdt_pkg::PER_RESET[CNT_W-1:0];
            end else if (per_wr) begin
                per_reg[h] <= bus_req.wdata[CNT_W-1:0];
            end
        end

        for (genvar i = 0; i < 4; i++) begin : g_chan
            localparam int W = h * 4 + i;
            localparam logic [7:0] A_CMP =
                8'(sdt_pkg::ADDR_LOWER_CMP + 8'(i) * sdt_pkg::CMP_ADDR_STRIDE + 8'(h));

            assign match[W] = (cnt_reg[h] == cmp_reg[h][i]);

            always_ff @(posedge clock) begin
                if (rst || soft_reset) begin
                    cmp_reg[h][i] <= '0;
                end else if (wr && bus_req.addr == A_CMP) begin
                    cmp_reg[h][i] <= bus_req.wdata[CNT_W-1:0];
                end
            end

            always_ff @(posedge clock) begin
                if (rst || soft_reset || restart[h]) begin
                    wg_reg[W] <= 1'b0;
                end else if (timer_off && wr && bus_req.addr == sdt_pkg::ADDR_OUT_VALUE) begin
                    wg_reg[W] <= bus_req.wdata[W];
                end else if (count_tick) begin
                    if (at_bottom[h]) begin
                        wg_reg[W] <= 1'b0;
                    end else if (match[W]) begin
                        wg_reg[W] <= 1'b1;
                    end
                end
            end
        end
    end

    // flags: hardware set beats software or dma clear
    always_comb begin
        flags_set = '0;
        flags_set[sdt_pkg::FLAG_LOWER_UF] = count_tick && at_bottom[0];
        flags_set[sdt_pkg::FLAG_UPPER_UF] = count_tick && at_bottom[1];
        flags_set[sdt_pkg::FLAG_MATCH_LSB +: 4] = count_tick ? match[3:0] : 4'h0;
        flags_clr = '0;
        if (wr && bus_req.addr == sdt_pkg::ADDR_FLAGS) begin
            flags_clr = bus_req.wdata;
        end
        if (bus_req.dma && wr && (bus_req.addr == sdt_pkg::ADDR_LOWER_CNT
                                  || bus_req.addr == sdt_pkg::ADDR_LOWER_PER)) begin
            flags_clr[sdt_pkg::FLAG_LOWER_UF] = 1'b1;
        end
        if (bus_req.dma && wr && (bus_req.addr == 8'(sdt_pkg::ADDR_LOWER_CNT + 8'h01)
                                  || bus_req.addr == 8'(sdt_pkg::ADDR_LOWER_PER + 8'h01))) begin
            flags_clr[sdt_pkg::FLAG_UPPER_UF] = 1'b1;
        end
        if (bus_req.dma && (wr || rd)) begin
            flags_clr[sdt_pkg::FLAG_MATCH_LSB +: 4] = lower_cmp_hit(bus_req.addr);
        end
    end

    always_ff @(posedge clock) begin
        if (rst || soft_reset) begin
            flags_reg <= sdt_pkg::REG_RESET;
        end else begin
            flags_reg <= (flags_reg & ~flags_clr) | flags_set;
        end
    end

    // event pulses, interrupt and dma request levels
    always_ff @(posedge clock) begin
        if (rst) begin
            events_reg  <= '0;
            irq_req_reg <= '0;
            dma_req_reg <= '0;
        end else begin
            events_reg.lower_uf    <= flags_set[sdt_pkg::FLAG_LOWER_UF];
            events_reg.upper_uf    <= flags_set[sdt_pkg::FLAG_UPPER_UF];
            events_reg.lower_match <= flags_set[sdt_pkg::FLAG_MATCH_LSB +: 4];
            for (int i = 0; i < 4; i++) begin
                irq_req_reg[2 + i] <= flags_reg[sdt_pkg::FLAG_MATCH_LSB + i]
                                      && cmp_level_reg[2 * i +: 2] != 2'h0;
            end
            irq_req_reg[0] <= flags_reg[sdt_pkg::FLAG_LOWER_UF] && |uf_level_reg[1:0];
            irq_req_reg[1] <= flags_reg[sdt_pkg::FLAG_UPPER_UF] && |uf_level_reg[3:2];
            dma_req_reg <= {flags_reg[sdt_pkg::FLAG_MATCH_LSB +: 4],
                            flags_reg[sdt_pkg::FLAG_UPPER_UF],
                            flags_reg[sdt_pkg::FLAG_LOWER_UF]};
        end
    end

    // port override of the pins
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_out_reg  <= '0;
            pin_oe_n_reg <= 8'hFF;
        end else begin
            pin_out_reg  <= ((wg_reg & {upper_channel_output_enable, lower_channel_output_enable})
                             | (port_output_value & ~{upper_channel_output_enable,
                                                      lower_channel_output_enable}))
                            ^ pin_invert_enable;
            pin_oe_n_reg <= ~pin_dir_out;
        end
    end

    // read mux
    always_comb begin
        rd_data_next = '0;
        case (bus_req.addr)
            sdt_pkg::ADDR_CLK_SEL:   rd_data_next = {4'h0, count_clock_source_select};
            sdt_pkg::ADDR_OUT_EN:    rd_data_next = {upper_channel_output_enable,
                                                     lower_channel_output_enable};
            sdt_pkg::ADDR_OUT_VALUE: rd_data_next = wg_reg;
            sdt_pkg::ADDR_BYTE_MODE: rd_data_next = {6'h00, byte_operation_select};
            sdt_pkg::ADDR_UF_LEVEL:  rd_data_next = {4'h0, uf_level_reg};
            sdt_pkg::ADDR_CMP_LEVEL: rd_data_next = cmp_level_reg;
            sdt_pkg::ADDR_COMMAND:   rd_data_next = 8'h00;
            sdt_pkg::ADDR_FLAGS:     rd_data_next = flags_reg;
            default: begin
                for (int h = 0; h < 2; h++) begin
                    if (bus_req.addr == 8'(sdt_pkg::ADDR_LOWER_CNT + 8'(h))) begin
                        rd_data_next = 8'(cnt_reg[h]);
                    end
                    if (bus_req.addr == 8'(sdt_pkg::ADDR_LOWER_PER + 8'(h))) begin
                        rd_data_next = 8'(per_reg[h]);
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (bus_req.addr == 8'(sdt_pkg::ADDR_LOWER_CMP
                                + 8'(i) * sdt_pkg::CMP_ADDR_STRIDE + 8'(h))) begin
                            rd_data_next = 8'(cmp_reg[h][i]);
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd ? rd_data_next : 8'h00;
        end
    end

    assign rd_data    = rd_data_reg;
    assign pin_out    = pin_out_reg;
    assign pin_oe_n   = pin_oe_n_reg;
    assign events_out = events_reg;
    assign irq_req    = irq_req_reg;
    assign dma_req    = dma_req_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_off_holds_count: assert property (
        timer_off && !wr |=> $stable(cnt_reg[0]) && $stable(cnt_reg[1]))
        else $error("counter moved with clock source off");
    a_split_only_count: assert property (
        !split_on && !wr |=> $stable(cnt_reg[0]))
        else $error("lower counter moved outside split operation");
    a_reload_at_bottom: assert property (
        count_tick && at_bottom[0] && !wr |=> cnt_reg[0] == $past(per_reg[0]))
        else $error("lower counter did not reload period at bottom");
    a_count_decrement: assert property (
        count_tick && !at_bottom[1] && !wr |=> cnt_reg[1] == $past(cnt_reg[1]) - 1'b1)
        else $error("upper counter did not step down");
    a_write_wins: assert property (
        wr && bus_req.addr == sdt_pkg::ADDR_LOWER_CNT
        |=> cnt_reg[0] == $past(bus_req.wdata[CNT_W-1:0]))
        else $error("counter write not taken at once");
    a_match_sets_flag: assert property (
        count_tick && match[0]
        |=> flags_reg[sdt_pkg::FLAG_MATCH_LSB] && events_reg.lower_match[0])
        else $error("lower match flag or event missing");
    a_wg_clear_bottom: assert property (
        count_tick && at_bottom[0] && !wr |=> !wg_reg[0])
        else $error("waveform not cleared at bottom");
    a_wg_set_match: assert property (
        count_tick && match[4] && !at_bottom[1] && !wr |=> wg_reg[4])
        else $error("upper waveform not set on match");
    a_pin_override: assert property (
        lower_channel_output_enable[1]
        |=> pin_out[1] == ($past(wg_reg[1]) ^ $past(pin_invert_enable[1])))
        else $error("pin not overridden by waveform");
    a_command_reads_zero: assert property (
        rd && bus_req.addr == sdt_pkg::ADDR_COMMAND |=> rd_data == 8'h00)
        else $error("command register read non zero");
    a_uf_dma_ack: assert property (
        bus_req.dma && wr && bus_req.addr == sdt_pkg::ADDR_LOWER_PER
        && !(count_tick && at_bottom[0])
        |=> !flags_reg[sdt_pkg::FLAG_LOWER_UF] ##1 !dma_req[0])
        else $error("dma period write did not clear underflow request");

    c_lower_underflow: cover property (count_tick && at_bottom[0] ##1 events_out.lower_uf);
    c_restart: cover property (restart[0] ##1 cnt_reg[0] == '0);
    c_pwm_high: cover property (lower_channel_output_enable[0] && wg_reg[0] ##1 pin_out[0]);

endmodule

`default_nettype wire

// ==== test/sdt_far_side.sv ====
// far-side model: port pins with pull-up and the event channels that clock the timer
`timescale 1ns/10ps
`default_nettype none
module sdt_far_side (
    // timing
    input  wire logic       clock,
    // pin and event side
    output logic [7:0]      ev_chan,
    output logic [7:0]      port_output_value,
    output logic [7:0]      pin_invert_enable,
    output logic [7:0]      pin_dir_out,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    output logic [7:0]      pad
);
    initial begin
        ev_chan = 8'h00;
        port_output_value = 8'h00;
        pin_invert_enable = 8'h00;
        pin_dir_out = 8'h00;
    end
    // a pin not driven floats to the pull-up level
    assign pad = (pin_out & ~pin_oe_n) | pin_oe_n;
    // one high cycle on a channel is one count clock
    task automatic pulse(input int ch);
        @(posedge clock);
        ev_chan <= 8'h01 << ch;
        @(posedge clock);
        ev_chan <= 8'h00;
    endtask
    task automatic setp(input logic [7:0] v, input logic [7:0] inv, input logic [7:0] dir);
        @(posedge clock);
        port_output_value <= v;
        pin_invert_enable <= inv;
        pin_dir_out <= dir;
    endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the split dual byte pwm timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                  clock, rst, lu, hu, ma, wl, wh;
    sdt_pkg::sdt_bus_req_t req;
    sdt_pkg::sdt_events_t  ev;
    logic [7:0]            rd_data, ev_chan, pov, inv, dir, pin_out, pin_oe_n, pad, v;
    logic [5:0]            irq, dma;
    logic [31:0]           seed;
    int                    errors, compares, ev_seen, ev_exp, lc, hc, lower_period_value, d;
    sdt_timer dut_u (.clock(clock), .rst(rst), .bus_req(req), .rd_data(rd_data),
        .ev_chan(ev_chan), .port_output_value(pov), .pin_invert_enable(inv),
        .pin_dir_out(dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .events_out(ev),
        .irq_req(irq), .dma_req(dma));
    sdt_far_side fp_u (.clock(clock), .ev_chan(ev_chan), .port_output_value(pov),
        .pin_invert_enable(inv), .pin_dir_out(dir), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pad(pad));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dt, input logic m = 1'b0);
        @(posedge clock);
        req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0, dma: m};
        @(posedge clock);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q, input logic m = 1'b0);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, dma: m};
        @(posedge clock);
        req <= '0;
        #1 q = rd_data;
    endtask
    always @(posedge clock) if (!rst) ev_seen <= ev_seen + $countones(ev);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        errors++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        ev_seen = 0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(sdt_pkg::ADDR_CLK_SEL, v); chk(v, 8'h00);
        rd(sdt_pkg::ADDR_LOWER_PER, v); chk(v, 8'hFF);
        seed = xs(32'd89509);
        fp_u.setp(seed[7:0], seed[15:8], seed[23:16] | 8'h11);
        wr(sdt_pkg::ADDR_CLK_SEL, 8'h0A);
        fp_u.pulse(2);
        rd(sdt_pkg::ADDR_LOWER_CNT, v); chk(v, 8'h00);
        chk(pin_oe_n, ~dir);
        wr(sdt_pkg::ADDR_LOWER_PER, 8'h03);
        wr(sdt_pkg::ADDR_LOWER_PER + 8'h01, 8'h05);
        wr(sdt_pkg::ADDR_LOWER_CMP, 8'h01);
        wr(sdt_pkg::ADDR_LOWER_CMP + 8'h01, 8'h02);
        wr(sdt_pkg::ADDR_OUT_EN, 8'h11);
        wr(sdt_pkg::ADDR_UF_LEVEL, 8'h01);
        wr(sdt_pkg::ADDR_CMP_LEVEL, 8'h01);
        wr(sdt_pkg::ADDR_BYTE_MODE, {6'h00, sdt_pkg::MODE_SPLIT});
        {lc, hc, lower_period_value, ev_exp, wl, wh} = {32'd0, 32'd0, 32'd3, 32'd0, 2'b00};
        for (int i = 0; i < 14; i++) begin
            if (i == 5) begin
                wr(sdt_pkg::ADDR_LOWER_PER, 8'h05);
                lower_period_value = 5;
            end
            if (i == 9) begin
                wr(sdt_pkg::ADDR_LOWER_CNT, 8'h02);
                lc = 2;
                rd(sdt_pkg::ADDR_LOWER_CNT, v); chk(v, 8'h02);
            end
            fp_u.pulse(2);
            lu = (lc == 0);
            ma = (lc == 1);
            hu = (hc == 0);
            ev_exp += lu + hu + ma + 3 * lu;
            if (lu) begin
                lc = lower_period_value;
                wl = 1'b0;
            end else begin
                wl |= ma;
                lc--;
            end
            if (hu) begin
                hc = 5;
                wh = 1'b0;
            end else begin
                wh |= (hc == 2);
                hc--;
            end
            repeat (3) @(posedge clock);
            rd(sdt_pkg::ADDR_LOWER_CNT, v); chk(v, 8'(lc));
            rd(sdt_pkg::ADDR_LOWER_CNT + 8'h01, v); chk(v, 8'(hc));
            rd(sdt_pkg::ADDR_FLAGS, v); chk(v, {{3{lu}}, ma, 2'b00, hu, lu});
            chk({2'b00, dma}, {2'b00, {3{lu}}, ma, hu, lu});
            chk({2'b00, irq}, {5'b00000, ma, 1'b0, lu});
            chk(pad, ((({3'b000, wh, 3'b000, wl} | (pov & 8'hEE)) ^ inv) & dir) | ~dir);
            wr(sdt_pkg::ADDR_FLAGS, 8'hFF);
        end
        repeat (3) @(posedge clock);
        chk(8'(ev_seen), 8'(ev_exp));
        wr(sdt_pkg::ADDR_LOWER_CNT, 8'h00);
        fp_u.pulse(2);
        rd(sdt_pkg::ADDR_FLAGS, v); chk(v & 8'h01, 8'h01);
        wr(sdt_pkg::ADDR_LOWER_PER, 8'h05, 1'b1);
        rd(sdt_pkg::ADDR_FLAGS, v); chk(v & 8'h01, 8'h00);
        wr(sdt_pkg::ADDR_FLAGS, 8'hFF);
        wr(sdt_pkg::ADDR_LOWER_CNT, 8'h01);
        fp_u.pulse(2);
        rd(sdt_pkg::ADDR_FLAGS, v); chk(v & 8'h10, 8'h10);
        rd(sdt_pkg::ADDR_LOWER_CMP, v, 1'b1);
        rd(sdt_pkg::ADDR_FLAGS, v); chk(v & 8'h10, 8'h00);
        wr(sdt_pkg::ADDR_COMMAND, 8'h09);
        rd(sdt_pkg::ADDR_LOWER_CNT, v); chk(v, 8'h00);
        chk({7'h00, pad[0]}, {7'h00, inv[0]});
        rd(sdt_pkg::ADDR_COMMAND, v); chk(v, 8'h00);
        for (int k = 1; k < 8; k++) begin
            d = (k < 5) ? (1 << (k - 1)) : (16 << (2 * (k - 4)));
            wr(sdt_pkg::ADDR_CLK_SEL, 8'(k));
            wr(sdt_pkg::ADDR_LOWER_CNT, 8'hF0);
            repeat (4 * d) @(posedge clock);
            rd(sdt_pkg::ADDR_LOWER_CNT, v); chk({7'h00, v inside {[8'hEA:8'hED]}}, 8'h01);
        end
        wr(sdt_pkg::ADDR_CLK_SEL, sdt_pkg::REG_RESET);
        wr(sdt_pkg::ADDR_COMMAND, 8'h0F);
        rd(sdt_pkg::ADDR_LOWER_PER, v); chk(v, 8'hFF);
        rd(sdt_pkg::ADDR_BYTE_MODE, v); chk(v, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
